// >>> rtl/ccs_defs.svh
// register offsets, field positions, reset values and sync depth for the comparator control block
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

`define CCS_CTRL_OFFSET 12'h000
`define CCS_CTRL_RESET 8'h00
`define CCS_EN0_BIT 0
`define CCS_EN1_BIT 1
`define CCS_EN2_BIT 2
`define CCS_RES0_BIT 5
`define CCS_RES1_BIT 6
`define CCS_RES2_BIT 7
`define CCS_NUM_CMP 3
`define CCS_SYNC_STAGES 3
`define CCS_RESP_OKAY 2'b00
`define CCS_RESP_SLVERR 2'b10

`endif

// >>> rtl/ccs_pkg.sv
// types shared by the comparator control block
`include "ccs_defs.svh"
package ccs_pkg;
    typedef logic [`CCS_NUM_CMP-1:0] ccs_vec_t;

    typedef struct packed {
        ccs_vec_t enable;
        ccs_vec_t sync1;
        ccs_vec_t sync2;
        ccs_vec_t sync3;
        ccs_vec_t result;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
    } ccs_state_t;
endpackage : ccs_pkg

// >>> rtl/ccs_comparator_control.sv
// comparator control and status register behind an axi4-lite slave
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.svh"

// Behaviour
// [RULE_01] comparator results reach no pin; software reads them from the control register only
// [RULE_02] bit 7 reads comparator 2 result: 1 when positive input exceeds reference
// [RULE_03] bit 6 reads comparator 1 result: 1 when positive input exceeds reference
// [RULE_04] bit 5 reads comparator 0 result: 1 when positive input exceeds reference
// [RULE_05] bits 4 and 3 always read zero and ignore writes
// [RULE_06] writable bit 2 enables comparator 2 when set
// [RULE_07] writable bit 1 enables comparator 1 when set
// [RULE_08] writable bit 0 enables comparator 0 when set
// [RULE_09] three independent comparators, each one result bit and one enable bit
// [RULE_10] results are synchronised into the clock domain; disabled comparators read zero (here the result clears one cycle after the enable bit)
module ccs_comparator_control
    import ccs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`CCS_NUM_CMP-1:0] cmp_raw_result,
    output logic [`CCS_NUM_CMP-1:0] cmp_enable
);

    ccs_state_t st_ff;
    ccs_state_t nxt_st;

    function automatic logic [7:0] ctrl_image(input ccs_vec_t en, input ccs_vec_t res);
        logic [7:0] v;
        v = 8'h00;
        v[`CCS_RES2_BIT] = res[2]; // RULE_02
        v[`CCS_RES1_BIT] = res[1]; // RULE_03
        v[`CCS_RES0_BIT] = res[0]; // RULE_04
        v[`CCS_EN2_BIT] = en[2];
        v[`CCS_EN1_BIT] = en[1];
        v[`CCS_EN0_BIT] = en[0];
        return v; // RULE_05
    endfunction : ctrl_image

    always_comb begin
        logic do_write;
        logic [7:0] wmask;
        do_write = 1'b0;
        wmask = 8'h00;
        nxt_st = st_ff;

        // three-stage sync; a change counts once stages two and three agree
        nxt_st.sync1 = cmp_raw_result; // RULE_10
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.sync3 = st_ff.sync2;
        for (int i = 0; i < `CCS_NUM_CMP; i++) begin
            if (!st_ff.enable[i]) begin
                nxt_st.result[i] = 1'b0; // RULE_10
            end else if (st_ff.sync2[i] == st_ff.sync3[i]) begin
                nxt_st.result[i] = st_ff.sync3[i]; // RULE_09
            end
        end

        // write side: address and data may arrive in either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
            nxt_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_held = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
            nxt_st.wready = 1'b0;
        end
        if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
            do_write = 1'b1;
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
            nxt_st.bvalid = 1'b1;
            if (st_ff.aw_addr[11:2] == 10'(`CCS_CTRL_OFFSET >> 2)) begin
                nxt_st.bresp = `CCS_RESP_OKAY;
            end else begin
                nxt_st.bresp = `CCS_RESP_SLVERR;
            end
        end
        if (do_write && st_ff.aw_addr[11:2] == 10'(`CCS_CTRL_OFFSET >> 2) && st_ff.w_strb[0]) begin
            wmask = st_ff.w_data[7:0];
            nxt_st.enable[2] = wmask[`CCS_EN2_BIT]; // RULE_06
            nxt_st.enable[1] = wmask[`CCS_EN1_BIT]; // RULE_07
            nxt_st.enable[0] = wmask[`CCS_EN0_BIT]; // RULE_08
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready = 1'b1;
        end

        // read side: one outstanding read, answered the cycle after the address
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid = 1'b1;
            if (s_axi_araddr[11:2] == 10'(`CCS_CTRL_OFFSET >> 2)) begin
                nxt_st.rdata = {24'h000000, ctrl_image(st_ff.enable, st_ff.result)}; // RULE_01
                nxt_st.rresp = `CCS_RESP_OKAY;
            end else begin
                nxt_st.rdata = 32'h00000000;
                nxt_st.rresp = `CCS_RESP_SLVERR;
            end
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
            nxt_st.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.enable <= ccs_vec_t'(`CCS_CTRL_RESET);
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
            st_ff.arready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rresp = st_ff.rresp;
    assign s_axi_rdata = st_ff.rdata;
    // enables drive the analog comparators; results stay internal
    assign cmp_enable = st_ff.enable; // RULE_09

endmodule : ccs_comparator_control
`default_nettype wire

// >>> verification/ccs_sva.sv
// assertion checker for the comparator control register block
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.svh"
module ccs_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rready,
    input wire logic [`CCS_NUM_CMP-1:0] cmp_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_rsv_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0 && s_axi_rdata[4:3] == 0)
        else $error("reserved bits set");
    chk_en_back: assert property ($rose(s_axi_rvalid) && s_axi_rresp == 2'b00 |-> s_axi_rdata[2:0] == $past(cmp_enable))
        else $error("enable readback");
    // a result may lag a raise of enable, but must be gone two edges after a clear
    chk_dis_zero: assert property ($rose(s_axi_rvalid) |-> (s_axi_rdata[7:5] & ~$past(cmp_enable, 2)) == 0)
        else $error("disabled result set");
    chk_en_write: assert property ($changed(cmp_enable) |-> $rose(s_axi_bvalid))
        else $error("enable moved");
    chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read overlap");
    chk_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not closed");
    chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write not closed");
endmodule : ccs_sva
`default_nettype wire

// >>> verification/ccs_comparator_control_bench.sv
// self-checking bench for the comparator control register block
`timescale 1ns/10ps
`default_nettype none
module ccs_comparator_control_bench;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0, cmp_raw_result = 0, cmp_enable;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] lf = 16'hdc3f;
    int n_errors = 0, cmp_count = 0, en = 0;
    ccs_comparator_control dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cmp_raw_result, .cmp_enable);
    initial forever #5 aclk = ~aclk;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    endtask : rd
    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(12'h000, 32'h0, 2'h0);
        for (int i = 0; i < 16; i++) begin
            lf = lfsr(lf);
            cmp_raw_result <= lf[7:5];
            if (lf[8]) en = lf[2:0];
            wr(12'h000, {lf, lf}, {3'h0, lf[8]}, 2'h0);
            repeat (5) @(posedge aclk);
            rd(12'h000, {24'h0, cmp_raw_result & en[2:0], 2'h0, en[2:0]}, 2'h0);
        end
        wr(12'h004, 32'hffffffff, 4'hf, 2'h2);
        rd(12'h004, 32'h0, 2'h2);
        @(posedge aclk);
        rd(12'h000, {24'h0, cmp_raw_result & en[2:0], 2'h0, en[2:0]}, 2'h0);
        complete_run();
    end
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end
endmodule : ccs_comparator_control_bench
bind ccs_comparator_control ccs_sva chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rready, .cmp_enable);
`default_nettype wire
